// ### hdl/pts_pkg.sv
// package: address map, field layout, states and timing of the position table sequencer
package pts_pkg;

   // ----------------------------------------------------------------
   // table geometry
   // ----------------------------------------------------------------
   localparam int unsigned N_TASKS = 32;
   localparam int unsigned IDX_W   = 5;
   localparam int unsigned N_PROF  = 8;
   localparam int unsigned PROF_W  = 3;
   localparam int unsigned LOOP_W  = 8;
   localparam int unsigned N_IRQ   = 4;
   localparam int unsigned ADDR_W  = 10;

   // ----------------------------------------------------------------
   // address map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] TBL_PROF_BASE = 10'h200;
   localparam logic [ADDR_W-1:0] REG_CTRL      = 10'h300;
   localparam logic [ADDR_W-1:0] REG_STATUS    = 10'h304;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 10'h308;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK  = 10'h30C;

   // word slots inside one 16-byte task entry
   localparam logic [1:0] W_POS    = 2'h0;
   localparam logic [1:0] W_MOTION = 2'h1;
   localparam logic [1:0] W_CTL    = 2'h2;
   localparam logic [1:0] W_REMAIN = 2'h3;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned SPD_LSB        = 0;
   localparam int unsigned DLY_LSB        = 16;
   localparam int unsigned CTL_NEXT_LSB   = 0;
   localparam int unsigned CTL_CHAIN_BIT  = 8;
   localparam int unsigned CTL_LEVEL_BIT  = 9;
   localparam int unsigned CTL_EDGE_BIT   = 10;
   localparam int unsigned CTL_AND_BIT    = 11;
   localparam int unsigned CTL_MODE_LSB   = 12;
   localparam int unsigned CTL_LAUNCH_LSB = 14;
   localparam int unsigned ACC_LSB        = 16;
   localparam int unsigned DEC_LSB        = 20;
   localparam int unsigned LOOPS_LSB      = 24;
   localparam int unsigned PROF_DEC_LSB   = 16;
   localparam int unsigned ST_ACTIVE_BIT  = 8;
   localparam int unsigned ST_PEND_BIT    = 9;
   localparam int unsigned ST_STOP_BIT    = 10;

   // launch policy codes
   localparam logic [1:0] LAUNCH_IGNORE  = 2'h0;
   localparam logic [1:0] LAUNCH_WAIT    = 2'h1;
   localparam logic [1:0] LAUNCH_PREEMPT = 2'h2;

   // interrupt status bits
   localparam int unsigned IRQ_FLOW_START = 0;
   localparam int unsigned IRQ_TASK_DONE  = 1;
   localparam int unsigned IRQ_FLOW_END   = 2;
   localparam int unsigned IRQ_FLOW_ABORT = 3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_DELAY, ST_CHAIN} pts_state_t;

endpackage : pts_pkg

// ### hdl/pts_gate.sv
// gate condition combiner for the chaining decision
module pts_gate (
   input  wire logic level_term_enable,
   input  wire logic edge_term_enable,
   input  wire logic and_select,
   input  wire logic level_term,
   input  wire logic edge_term,
   output logic      gate_ok
);

   // ----------------------------------------------------------------
   // combine the enabled terms
   // ----------------------------------------------------------------
   always_comb begin
      unique case ({level_term_enable, edge_term_enable})
         2'b00:   gate_ok = 1'b1;
         2'b10:   gate_ok = level_term;
         2'b01:   gate_ok = edge_term;
         default: gate_ok = and_select ? (level_term & edge_term)
                                       : (level_term | edge_term);
      endcase
   end

endmodule : pts_gate

// ### hdl/pts_sequencer.sv
// position table sequencer with ahb-lite register access
//
// Functional notes
// - start input rising edge triggers the entry task, subject to its launch policy.
// - after a task, advance to its next index or halt.
// - current index output always shows the task being executed.
// - table holds 32 tasks, index 0 to 31.
// - each task has position, speed and millisecond delay.
// - each task picks acceleration and deceleration from an eight-entry profile table.
// - control bits 0-4 give next index; bits 5-7 reserved.
// - bit 8 set chains when gate and loop check pass; clear stops.
// - bit 9 enables the level term, the level gate input's present level.
// - bit 10 enables the edge term, a rising edge on the edge gate input.
// - with both terms on, bit 11 picks and (1) or or (0).
// - no term on gives condition 1; one term gives that term.
// - bits 12-13 select absolute, relative to target, or relative to actual.
// - trigger during a move: ignore, wait without delay, or preempt, per policy.
// - nonzero loop limit stops flow when this or next task's count is used up.
// - remaining counts load at flow start and drop once per execution.
// - abort edge or start function removal ends flow after the current task.
// - error or operating mode change aborts the flow at once.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
module pts_sequencer
   import pts_pkg::*;
#(
   parameter int unsigned MS_CYC = MS_CYCLES
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic              table_start_input,
   input  wire logic              start_function_assigned,
   input  wire logic              table_abort_input,
   input  wire logic              level_gate_input,
   input  wire logic              edge_gate_input,
   input  wire logic              drive_error,
   input  wire logic              mode_change,
   input  wire logic              move_done,
   output logic                   move_start,
   output logic                   move_abort,
   output logic [31:0]            move_position,
   output logic [1:0]             move_mode,
   output logic [15:0]            move_speed,
   output logic [15:0]            move_accel,
   output logic [15:0]            move_decel,
   output logic [IDX_W-1:0]       current_index,
   output logic                   flow_active,
   output logic                   irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [N_TASKS-1:0][31:0]       w_pos;
      logic [N_TASKS-1:0][31:0]       w_motion;
      logic [N_TASKS-1:0][31:0]       w_ctl;
      logic [N_TASKS-1:0][LOOP_W-1:0] rem;
      logic [N_PROF-1:0][31:0]        prof;
      pts_state_t                     st;
      logic [IDX_W-1:0]               entry_idx;
      logic [IDX_W-1:0]               cur_idx;
      logic                           pend;
      logic [IDX_W-1:0]               pend_idx;
      logic                           stop_req;
      logic                           edge_seen;
      logic                           start_prev;
      logic                           abort_prev;
      logic                           func_prev;
      logic                           edge_prev;
      logic [31:0]                    tick_cnt;
      logic                           ms_tick;
      logic [15:0]                    dly_cnt;
      logic [N_IRQ-1:0]               irq_stat;
      logic [N_IRQ-1:0]               irq_mask;
      logic                           dph;
      logic                           dwr;
      logic [ADDR_W-1:0]              daddr;
      logic                           mv_start;
      logic                           mv_abort;
      logic [31:0]                    mv_pos;
      logic [1:0]                     mv_mode;
      logic [15:0]                    mv_speed;
      logic [15:0]                    mv_accel;
      logic [15:0]                    mv_decel;
      logic [31:0]                    rdata;
   } pts_regs_t;

   pts_regs_t        s_q;
   pts_regs_t        s_d;
   logic             start_rise;
   logic             abort_rise;
   logic             func_fall;
   logic             edge_rise;
   logic             gate_ok;
   logic             launch;
   logic [IDX_W-1:0] lidx;
   logic             end_flow;
   logic [31:0]      lw;
   logic [31:0]      cw;
   logic [31:0]      nw;
   logic [IDX_W-1:0] nidx;
   logic [1:0]       policy;
   logic [N_IRQ-1:0] evt;

   // ----------------------------------------------------------------
   // input edges and gate evaluation
   // ----------------------------------------------------------------
   assign start_rise = table_start_input & ~s_q.start_prev;
   assign abort_rise = table_abort_input & ~s_q.abort_prev;
   assign func_fall  = ~start_function_assigned & s_q.func_prev;
   assign edge_rise  = edge_gate_input & ~s_q.edge_prev;
   assign cw         = s_q.w_ctl[s_q.cur_idx];
   assign nidx       = cw[CTL_NEXT_LSB +: IDX_W];
   assign nw         = s_q.w_ctl[nidx];
   assign policy     = s_q.w_ctl[s_q.entry_idx][CTL_LAUNCH_LSB +: 2];

   // an edge is remembered from launch on, so a short pulse during the move still counts
   pts_gate u_gate (
      .level_term_enable (cw[CTL_LEVEL_BIT]),
      .edge_term_enable  (cw[CTL_EDGE_BIT]),
      .and_select        (cw[CTL_AND_BIT]),
      .level_term        (level_gate_input),
      .edge_term         (s_q.edge_seen | edge_rise),
      .gate_ok           (gate_ok)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      launch   = 1'b0;
      lidx     = '0;
      end_flow = 1'b0;
      evt      = '0;
      lw       = '0;

      s_d.start_prev = table_start_input;
      s_d.abort_prev = table_abort_input;
      s_d.func_prev  = start_function_assigned;
      s_d.edge_prev  = edge_gate_input;
      s_d.mv_start   = 1'b0;
      s_d.mv_abort   = 1'b0;

      // millisecond tick, restarted when a delay begins so delays are exact
      s_d.ms_tick = 1'b0;
      if (s_q.tick_cnt == 32'(MS_CYC - 1)) begin
         s_d.tick_cnt = '0;
         s_d.ms_tick  = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 32'h00000001;
      end

      if (edge_rise) begin
         s_d.edge_seen = 1'b1;
      end
      if (abort_rise || func_fall) begin
         s_d.stop_req = 1'b1;
      end

      // ---- bus data phase ----
      s_d.dph = hsel & hready & htrans[1];
      s_d.dwr = hwrite;
      s_d.daddr = haddr[ADDR_W-1:0];
      if (s_q.dph && s_q.dwr) begin
         if (!s_q.daddr[ADDR_W-1]) begin
            unique case (s_q.daddr[3:2])
               W_POS:    s_d.w_pos[s_q.daddr[8:4]]    = hwdata;
               W_MOTION: s_d.w_motion[s_q.daddr[8:4]] = hwdata;
               W_CTL:    s_d.w_ctl[s_q.daddr[8:4]]    = hwdata;
               W_REMAIN: ;
            endcase
         end else if (s_q.daddr[ADDR_W-1:5] == TBL_PROF_BASE[ADDR_W-1:5]) begin
            s_d.prof[s_q.daddr[4:2]] = hwdata;
         end else if (s_q.daddr == REG_CTRL) begin
            s_d.entry_idx = hwdata[IDX_W-1:0];
         end else if (s_q.daddr == REG_IRQ_MASK) begin
            s_d.irq_mask = hwdata[N_IRQ-1:0];
         end
      end else if (s_q.dph && (s_q.daddr == REG_IRQ_STAT)) begin
         s_d.irq_stat = '0;
      end

      // ---- sequencing ----
      unique case (s_q.st)
         ST_IDLE: begin
            if (start_rise && !drive_error) begin
               for (int i = 0; i < N_TASKS; i++) begin
                  s_d.rem[i] = s_q.w_ctl[i][LOOPS_LSB +: LOOP_W];
               end
               // a stop edge in the start cycle is kept, not lost
               s_d.stop_req = abort_rise | func_fall;
               s_d.pend     = 1'b0;
               evt[IRQ_FLOW_START] = 1'b1;
               launch = 1'b1;
               lidx   = s_q.entry_idx;
            end
         end
         ST_MOVE: begin
            if (start_rise) begin
               unique case (policy)
                  LAUNCH_WAIT: begin
                     s_d.pend     = 1'b1;
                     s_d.pend_idx = s_q.entry_idx;
                  end
                  LAUNCH_PREEMPT: begin
                     s_d.mv_abort = 1'b1;
                     launch = 1'b1;
                     lidx   = s_q.entry_idx;
                  end
                  default: ;
               endcase
            end
            if (move_done && !launch) begin
               evt[IRQ_TASK_DONE] = 1'b1;
               if (s_d.stop_req) begin
                  end_flow = 1'b1;
               end else if (s_q.pend) begin
                  s_d.pend = 1'b0;
                  launch = 1'b1;
                  lidx   = s_q.pend_idx;
               end else begin
                  s_d.dly_cnt  = s_q.w_motion[s_q.cur_idx][DLY_LSB +: 16];
                  s_d.tick_cnt = '0;
                  s_d.ms_tick  = 1'b0;
                  s_d.st       = ST_DELAY;
               end
            end
         end
         ST_DELAY: begin
            // no move runs here, so a new trigger starts at once unless the entry task's loop count is used up
            if (start_rise) begin
               launch = 1'b1;
               lidx   = s_q.entry_idx;
            end else if (s_q.stop_req) begin
               end_flow = 1'b1;
            end else if (s_q.dly_cnt == 16'h0000) begin
               s_d.st = ST_CHAIN;
            end else if (s_q.ms_tick) begin
               s_d.dly_cnt = s_q.dly_cnt - 16'h0001;
            end
         end
         ST_CHAIN: begin
            // a closed gate holds the flow here until it opens, a start edge relaunches the entry task or an abort arrives
            if (start_rise) begin
               launch = 1'b1;
               lidx   = s_q.entry_idx;
            end else if (s_q.stop_req || !cw[CTL_CHAIN_BIT]) begin
               end_flow = 1'b1;
            end else if ((cw[LOOPS_LSB +: LOOP_W] != '0 && s_q.rem[s_q.cur_idx] == '0)
                      || (nw[LOOPS_LSB +: LOOP_W] != '0 && s_q.rem[nidx] == '0)) begin
               end_flow = 1'b1;
            end else if (gate_ok) begin
               launch = 1'b1;
               lidx   = nidx;
            end
         end
         default: s_d.st = ST_IDLE;
      endcase

      // ---- task launch ----
      if (launch && !((drive_error || mode_change) && s_q.st != ST_IDLE)) begin
         lw = s_q.w_ctl[lidx];
         if (lw[LOOPS_LSB +: LOOP_W] != '0 && s_d.rem[lidx] == '0) begin
            end_flow = 1'b1;
         end else begin
            if (lw[LOOPS_LSB +: LOOP_W] != '0) begin
               s_d.rem[lidx] = s_d.rem[lidx] - 8'h01;
            end
            s_d.cur_idx   = lidx;
            s_d.st        = ST_MOVE;
            s_d.edge_seen = 1'b0;
            s_d.mv_start  = 1'b1;
            s_d.mv_pos    = s_q.w_pos[lidx];
            s_d.mv_speed  = s_q.w_motion[lidx][SPD_LSB +: 16];
            s_d.mv_mode   = lw[CTL_MODE_LSB +: 2];
            s_d.mv_accel  = s_q.prof[lw[ACC_LSB +: PROF_W]][15:0];
            s_d.mv_decel  = s_q.prof[lw[DEC_LSB +: PROF_W]][PROF_DEC_LSB +: 16];
         end
      end

      if (end_flow) begin
         s_d.st   = ST_IDLE;
         s_d.pend = 1'b0;
         evt[IRQ_FLOW_END] = 1'b1;
      end

      // error or mode change overrides everything and stops the core too
      if ((drive_error || mode_change) && s_q.st != ST_IDLE) begin
         s_d.st       = ST_IDLE;
         s_d.pend     = 1'b0;
         s_d.mv_start = 1'b0;
         s_d.mv_abort = 1'b1;
         evt = '0;
         evt[IRQ_FLOW_ABORT] = 1'b1;
      end

      // set after the read clear, so an event in the clearing cycle survives
      s_d.irq_stat = s_d.irq_stat | evt;

      // read data taken from the next state, so a write just before is seen
      s_d.rdata = '0;
      if (hsel && hready && htrans[1] && !hwrite) begin
         if (!haddr[ADDR_W-1]) begin
            unique case (haddr[3:2])
               W_POS:    s_d.rdata = s_d.w_pos[haddr[8:4]];
               W_MOTION: s_d.rdata = s_d.w_motion[haddr[8:4]];
               W_CTL:    s_d.rdata = s_d.w_ctl[haddr[8:4]];
               W_REMAIN: s_d.rdata = {24'h000000, s_d.rem[haddr[8:4]]};
            endcase
         end else if (haddr[ADDR_W-1:5] == TBL_PROF_BASE[ADDR_W-1:5]) begin
            s_d.rdata = s_d.prof[haddr[4:2]];
         end else if (haddr[ADDR_W-1:0] == REG_CTRL) begin
            s_d.rdata[IDX_W-1:0] = s_d.entry_idx;
         end else if (haddr[ADDR_W-1:0] == REG_STATUS) begin
            s_d.rdata[IDX_W-1:0]     = s_d.cur_idx;
            s_d.rdata[ST_ACTIVE_BIT] = (s_d.st != ST_IDLE);
            s_d.rdata[ST_PEND_BIT]   = s_d.pend;
            s_d.rdata[ST_STOP_BIT]   = s_d.stop_req;
         end else if (haddr[ADDR_W-1:0] == REG_IRQ_STAT) begin
            s_d.rdata[N_IRQ-1:0] = s_d.irq_stat;
         end else if (haddr[ADDR_W-1:0] == REG_IRQ_MASK) begin
            s_d.rdata[N_IRQ-1:0] = s_d.irq_mask;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // zero wait states; every access is accepted
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   assign hrdata        = s_q.rdata;
   assign move_start    = s_q.mv_start;
   assign move_abort    = s_q.mv_abort;
   assign move_position = s_q.mv_pos;
   assign move_mode     = s_q.mv_mode;
   assign move_speed    = s_q.mv_speed;
   assign move_accel    = s_q.mv_accel;
   assign move_decel    = s_q.mv_decel;
   assign current_index = s_q.cur_idx;
   assign flow_active   = (s_q.st != ST_IDLE);
   assign irq           = |(s_q.irq_stat & s_q.irq_mask);

endmodule : pts_sequencer

// ### verif/pts_chk.sv
// checker: port-level properties of the position table sequencer
module pts_chk
   import pts_pkg::*;
#(
   parameter int unsigned MS_CYC = MS_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic table_start_input,
   input wire logic start_function_assigned,
   input wire logic drive_error,
   input wire logic mode_change,
   input wire logic move_start,
   input wire logic move_abort,
   input wire logic [31:0] move_position,
   input wire logic [1:0] move_mode,
   input wire logic [IDX_W-1:0] current_index,
   input wire logic flow_active,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------
   // properties
   // ----------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   chk_launch_edge: assert property ($rose(table_start_input) && !flow_active
      && !drive_error && !mode_change && start_function_assigned |-> ##[1:2] move_start)
      else $error("start edge did not launch");
   chk_start_once: assert property (move_start |=> !move_start)
      else $error("move start longer than one cycle");
   chk_launch_active: assert property (move_start |-> flow_active)
      else $error("launch outside a flow");
   chk_index_moves: assert property ($changed(current_index) |-> move_start)
      else $error("index changed without launch");
   chk_fields_hold: assert property (!move_start |-> $stable(move_position)
      && $stable(move_mode)) else $error("move fields changed without launch");
   chk_error_abort: assert property ($rose(drive_error) && flow_active
      |-> ##[1:2] move_abort ##[0:1] !flow_active) else $error("error did not abort");
   chk_idle_quiet: assert property (move_abort |-> $past(flow_active))
      else $error("abort while idle");

   // a launch and a preempt and an interrupt should all be seen at least once
   cov_launch: cover property (move_start);
   cov_preempt: cover property (move_start && move_abort);
   cov_irq: cover property ($rose(irq));
endmodule : pts_chk

bind pts_sequencer pts_chk #(.MS_CYC(MS_CYC)) u_chk (.hclk, .hresetn, .hreadyout, .hresp,
   .table_start_input, .start_function_assigned, .drive_error, .mode_change, .move_start,
   .move_abort, .move_position, .move_mode, .current_index, .flow_active, .irq);

// ### verif/pts_core_model.sv
// partner: motion core model that reports each launched move done lat+1 cycles after it samples move_start
module pts_core_model (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       move_start,
   input  wire logic       move_abort,
   input  wire logic [7:0] lat,
   output logic            move_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       busy_q;
   logic [7:0] cnt_q;
   // a preempting launch restarts the move; a bare abort drops it with no done
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
         move_done <= 1'b0;
      end else begin
         move_done <= busy_q && cnt_q == 8'h00 && !move_start && !move_abort;
         if (move_start) begin
            busy_q <= 1'b1;
            cnt_q <= lat;
         end else if (move_abort || cnt_q == 8'h00) begin
            busy_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule : pts_core_model

// ### verif/tb_position_table_sequencer.sv
// testbench: chained flows, gates, launch policies, loops, errors and registers
module tb_position_table_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   import pts_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, move_position, r, p3, p7, a2, a5;
   logic [31:0] seed = 32'h5E;
   logic [1:0] htrans = 2'h0, move_mode;
   logic [2:0] hsize = 3'h2;
   logic table_start_input = 1'b0, start_function_assigned = 1'b1, table_abort_input = 1'b0;
   logic level_gate_input = 1'b0, edge_gate_input = 1'b0, drive_error = 1'b0;
   logic mode_change = 1'b0, move_done, move_start, move_abort, flow_active, irq;
   logic [15:0] move_speed, move_accel, move_decel;
   logic [4:0] current_index;
   logic [7:0] lat = 8'h06;
   logic [5:0] gt [6] = '{6'h0D, 6'h08, 6'h13, 6'h3C, 6'h1B, 6'h01};
   logic [86:0] exq [$];
   int failures = 0, checks = 0;

   initial forever #25 hclk = ~hclk;
   pts_sequencer #(.MS_CYC(4)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .table_start_input,
      .start_function_assigned, .table_abort_input, .level_gate_input, .edge_gate_input,
      .drive_error, .mode_change, .move_done, .move_start, .move_abort, .move_position,
      .move_mode, .move_speed, .move_accel, .move_decel, .current_index, .flow_active, .irq);
   pts_core_model core (.hclk, .hresetn, .move_start, .move_abort, .lat, .move_done);

   // ----------
   // helpers
   // ----------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(input logic [127:0] e, input logic [127:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask : bus
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(e, r);
   endtask : rd
   task automatic go(input logic [4:0] e);
      bus(1'b1, 32'h300, {27'h0, e});
      table_start_input <= 1'b1;
   endtask : go
   // bounded wait for idle so a stuck flow is reported, not hung on
   task automatic fin(input string s);
      int n;
      n = 0;
      while (flow_active !== 1'b0 && n < 400) begin
         @(posedge hclk);
         n++;
      end
      table_start_input <= 1'b0;
      @(posedge hclk);
      chk(1'b0, n >= 400);
      chk(64'h0, exq.size());
      $display("test %s done", s);
   endtask : fin
   task automatic finish_test();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   // every launch is compared with the oldest noted expectation
   always @(posedge hclk) begin
      if (move_start === 1'b1) begin
         if (exq.size() == 0) chk(64'h0, 64'h1);
         else chk(exq.pop_front(), {current_index, move_mode, move_speed, move_decel,
                                    move_accel, move_position});
      end
   end

   initial begin
      repeat (20000) @(posedge hclk);
      failures++;
      finish_test();
   end

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      p3 = xs();
      p7 = xs();
      a2 = xs();
      a5 = xs();
      bus(1'b1, 32'h208, a2);
      bus(1'b1, 32'h214, a5);
      bus(1'b1, 32'h030, p3);
      bus(1'b1, 32'h034, 32'h0001_0100);
      bus(1'b1, 32'h038, 32'h0052_1107);
      bus(1'b1, 32'h070, p7);
      bus(1'b1, 32'h078, 32'h0005_2000);
      bus(1'b1, 32'h30C, 32'h4);
      exq.push_back({5'd3, 2'h1, 16'h0100, a5[31:16], a2[15:0], p3});
      exq.push_back({5'd7, 2'h2, 32'h0, a5[15:0], p7});
      go(5'd3);
      repeat (4) @(posedge hclk);
      fin("chain");
      chk(1'b1, irq);
      rd(32'h308, 32'h7);
      rd(32'h3F0, 32'h0);
      chk(1'b0, irq);
      rd(32'h304, 32'h7);
      foreach (gt[i]) begin
         bus(1'b1, 32'h0A8, {20'h0, gt[i][5:3], 9'h10B});
         level_gate_input <= gt[i][2];
         exq.push_back({5'd10, 82'h0});
         if (gt[i][0]) exq.push_back({5'd11, 82'h0});
         go(5'd10);
         repeat (4) @(posedge hclk);
         edge_gate_input <= gt[i][1];
         repeat (20) @(posedge hclk);
         edge_gate_input <= 1'b0;
         table_abort_input <= 1'b1;
         fin("gate");
         table_abort_input <= 1'b0;
      end
      lat <= 8'h0C;
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, 32'h148, {16'h0, 2'(p), 14'h0});
         exq.push_back({5'd20, 82'h0});
         if (p == 1 || p == 2) exq.push_back({5'd20, 82'h0});
         go(5'd20);
         repeat (5) @(posedge hclk);
         table_start_input <= 1'b0;
         @(posedge hclk);
         table_start_input <= 1'b1;
         repeat (4) @(posedge hclk);
         fin("launch");
      end
      lat <= 8'h04;
      bus(1'b1, 32'h198, 32'h0200_0119);
      repeat (2) exq.push_back({5'd25, 82'h0});
      go(5'd25);
      repeat (4) @(posedge hclk);
      fin("loops");
      rd(32'h19C, 32'h0);
      // start function removal, then a mode change, each during the first move
      for (int k = 0; k < 2; k++) begin
         exq.push_back({5'd25, 82'h0});
         go(5'd25);
         repeat (4) @(posedge hclk);
         if (k == 0) start_function_assigned <= 1'b0;
         else mode_change <= 1'b1;
         @(posedge hclk);
         mode_change <= 1'b0;
         fin("stop");
         start_function_assigned <= 1'b1;
      end
      rd(32'h308, 32'hF);
      lat <= 8'h0A;
      bus(1'b1, 32'h30C, 32'h8);
      exq.push_back({5'd25, 82'h0});
      go(5'd25);
      repeat (4) @(posedge hclk);
      drive_error <= 1'b1;
      fin("error");
      chk(1'b1, irq);
      drive_error <= 1'b0;
      bus(1'b0, 32'h308, 32'h0);
      chk(1'b1, r[3]);
      finish_test();
   end
endmodule : tb_position_table_sequencer
